// ### dfs_pkg.sv
// Shared constants, types and carriers of the fieldbus status and reference block
package dfs_pkg;

   // ***********************************************
   // Register offsets (holding register numbers)
   // ***********************************************
   localparam logic [15:0] DFS_OFS_REF_ONE = 16'h9C42;
   localparam logic [15:0] DFS_OFS_REF_TWO = 16'h9C43;
   localparam logic [15:0] DFS_OFS_STATUS  = 16'h9C44;
   localparam logic [15:0] DFS_OFS_FREQ    = 16'h9C45;
   localparam logic [15:0] DFS_OFS_CURR    = 16'h9C46;

   // ***********************************************
   // Reset values and scaling figures
   // ***********************************************
   localparam logic [15:0] DFS_WORD_RESET   = 16'h0000;
   localparam int          DFS_REF_ONE_FULL = 32'h0000_4E20; // 20000 counts = max frequency
   localparam int          DFS_REF_TWO_FULL = 32'h0000_2710; // 10000 counts = reference two max
   localparam int          DFS_AI_NEUTRAL   = 32'h0000_1388; // 50.00 % in 0.01 % steps
   localparam int          DFS_SYNC_STAGES  = 32'h0000_0002;

   // ***********************************************
   // Status word bit positions
   // ***********************************************
   localparam int DFS_SW_RDY_ON   = 32'h0000_0000;
   localparam int DFS_SW_RDY_OP   = 32'h0000_0001;
   localparam int DFS_SW_OP_EN    = 32'h0000_0002;
   localparam int DFS_SW_FAULT    = 32'h0000_0003;
   localparam int DFS_SW_COAST    = 32'h0000_0004;
   localparam int DFS_SW_ESTOP    = 32'h0000_0005;
   localparam int DFS_SW_INHIBIT  = 32'h0000_0006;
   localparam int DFS_SW_ALARM    = 32'h0000_0007;
   localparam int DFS_SW_AT_REF   = 32'h0000_0008;
   localparam int DFS_SW_REMOTE   = 32'h0000_0009;
   localparam int DFS_SW_SUPV     = 32'h0000_000A;
   localparam int DFS_SW_LOC_TWO  = 32'h0000_000B;
   localparam int DFS_SW_RUN_PERM = 32'h0000_000C;

   // ***********************************************
   // Types
   // ***********************************************
   typedef enum logic [1:0]
   {
      DFS_SRC_OTHER    = 2'h0,
      DFS_SRC_FIELDBUS = 2'h1,
      DFS_SRC_PLUS     = 2'h2,
      DFS_SRC_TIMES    = 2'h3
   } dfs_source_type;

   typedef struct packed
   {
      logic ready_to_switch_on;
      logic ready_to_operate;
      logic operation_enabled;
      logic fault_present;
      logic coast_off_inactive;
      logic emergency_stop_inactive;
      logic switch_on_inhibited;
      logic alarm_active;
      logic at_reference;
      logic remote_control;
      logic supervision_one_high;
      logic location_two_selected;
   } dfs_drive_flags_type;

   typedef struct packed
   {
      dfs_source_type ref_one_source;
      dfs_source_type ref_two_source;
      logic [15:0]    max_output_frequency;
      logic [15:0]    reference_two_maximum;
      logic [13:0]    analog_input_one;
   } dfs_config_type;

   typedef struct packed
   {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } dfs_reg_req_type;

endpackage : dfs_pkg

// ### dfs_ref_correct.sv
// Analog correction of one fieldbus reference
`timescale 1ns/100ps
module dfs_ref_correct #(
   parameter int FULL_SCALE = dfs_pkg::DFS_REF_ONE_FULL
)(
   input  wire logic                  ref_clk,
   input  wire logic                  nrst,
   input  wire logic [15:0]           fieldbus_ref,
   input  wire dfs_pkg::dfs_source_type mode,
   input  wire logic [13:0]           analog_input_one,
   output      logic signed [17:0]    corrected
);

   // ***********************************************
   // Correction arithmetic
   // ***********************************************
   typedef struct packed
   {
      logic signed [17:0] corr;
   } dfs_corr_state_type;

   dfs_corr_state_type st_r;
   dfs_corr_state_type st_nxt;
   logic signed [17:0] ref_s;
   logic signed [17:0] ai_dev;
   logic signed [35:0] prod;

   // Offset analog value so 50 % is neutral, scaled to reference counts
   always_comb
   begin
      ref_s  = 18'($signed(fieldbus_ref));                                      // RULE11
      ai_dev = 18'($signed({4'h0, analog_input_one}) - 18'(dfs_pkg::DFS_AI_NEUTRAL)); // RULE17
      prod   = 36'(ref_s) * 36'($signed({4'h0, analog_input_one}));
      st_nxt = st_r;
      case (mode)
         dfs_pkg::DFS_SRC_PLUS:                                                 // RULE19
            st_nxt.corr = 18'(ref_s + 18'((36'(ai_dev) * 36'(FULL_SCALE)) / 36'(dfs_pkg::DFS_REF_TWO_FULL)));
         dfs_pkg::DFS_SRC_TIMES:                                                // RULE20
            st_nxt.corr = 18'(prod / 36'(dfs_pkg::DFS_AI_NEUTRAL));
         default:
            st_nxt.corr = ref_s;                                                // RULE18
      endcase
   end

   // State register
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign corrected = st_r.corr;

endmodule : dfs_ref_correct

// ### dfs_status_word.sv
// Status word assembly with run-permit pin synchroniser
`timescale 1ns/100ps
module dfs_status_word (
   input  wire logic                         ref_clk,
   input  wire logic                         nrst,
   input  wire dfs_pkg::dfs_drive_flags_type flags,
   input  wire logic                         run_permit_pin,
   output      logic [15:0]                  status_word
);

   typedef struct packed
   {
      logic [1:0]  sync;
      logic [15:0] word;
   } dfs_sw_state_type;

   dfs_sw_state_type st_r;
   dfs_sw_state_type st_nxt;

   // ***********************************************
   // Word composition
   // ***********************************************
   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.sync = {st_r.sync[0], run_permit_pin};
      st_nxt.word = dfs_pkg::DFS_WORD_RESET;                                  // RULE9
      st_nxt.word[dfs_pkg::DFS_SW_RDY_ON]   = flags.ready_to_switch_on;       // RULE2
      st_nxt.word[dfs_pkg::DFS_SW_RDY_OP]   = flags.ready_to_operate;         // RULE2
      st_nxt.word[dfs_pkg::DFS_SW_OP_EN]    = flags.operation_enabled;        // RULE2
      st_nxt.word[dfs_pkg::DFS_SW_FAULT]    = flags.fault_present;            // RULE2
      st_nxt.word[dfs_pkg::DFS_SW_COAST]    = flags.coast_off_inactive;       // RULE2
      st_nxt.word[dfs_pkg::DFS_SW_ESTOP]    = flags.emergency_stop_inactive;  // RULE2
      st_nxt.word[dfs_pkg::DFS_SW_INHIBIT]  = flags.switch_on_inhibited;      // RULE2
      st_nxt.word[dfs_pkg::DFS_SW_ALARM]    = flags.alarm_active;             // RULE3
      st_nxt.word[dfs_pkg::DFS_SW_AT_REF]   = flags.at_reference;             // RULE4
      st_nxt.word[dfs_pkg::DFS_SW_REMOTE]   = flags.remote_control;           // RULE5
      st_nxt.word[dfs_pkg::DFS_SW_SUPV]     = flags.supervision_one_high;     // RULE6
      st_nxt.word[dfs_pkg::DFS_SW_LOC_TWO]  = flags.location_two_selected;    // RULE7
      st_nxt.word[dfs_pkg::DFS_SW_RUN_PERM] = st_r.sync[1];                   // RULE8
   end

   // State register
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign status_word = st_r.word;                                            // RULE1

endmodule : dfs_status_word

// ### dfs_fieldbus_if.sv
// Fieldbus status word, speed references and actual values of the drive
`timescale 1ns/100ps
// Functional notes
// [RULE1] Drive builds a status word and returns it when the master reads it.
// [RULE2] Bits 0-6: ready on, ready operate, enabled, fault, coast/estop inactive, inhibit.
// [RULE3] Bit 7 is set while any alarm is active.
// [RULE4] Bit 8 is set while actual value is within tolerance of reference.
// [RULE5] Bit 9 is set under remote control, clear under local control.
// [RULE6] Bit 10 is set when first supervised quantity is at or above limit.
// [RULE7] Bit 11 is set when external location two is selected.
// [RULE8] Bit 12 follows the run-permit input; bits 13-15 are unused.
// [RULE9] Unused status bits 13 to 15 always read zero.
// [RULE10] Each reference word is 16 bits: sign plus 15-bit magnitude.
// [RULE11] Negative reference means reverse, coded as two's complement.
// [RULE12] Reference one is used only if its source is fieldbus and location one active.
// [RULE13] Reference two is used only if its source is fieldbus and location two active.
// [RULE14] Reference two: 10000 equals configured maximum; the minimum is ignored.
// [RULE15] Reference one: 20000 equals the maximum output frequency.
// [RULE16] Source choices: fieldbus alone, plus analog, or times analog.
// [RULE17] Analog correction input is a percentage from 0 to 100.
// [RULE18] Analog input at 50 percent leaves the reference unchanged.
// [RULE19] Additive mode adds the analog percentage offset by 50 percent.
// [RULE20] Multiplicative mode multiplies by analog percentage and divides by 50.
// [RULE21] Actual values are read-only signed 16-bit words in two's complement.
// [RULE22] First actual value is output frequency, 5000 counts per 50 Hz.
// [RULE23] Second actual value is output current, 10 counts per 1 A.
module dfs_fieldbus_if (
   input  wire logic                         ref_clk,
   input  wire logic                         nrst,
   input  wire dfs_pkg::dfs_reg_req_type     reg_req,
   output      logic [15:0]                  reg_rdata,
   output      logic                         reg_rvalid,
   input  wire dfs_pkg::dfs_drive_flags_type drive_flags,
   input  wire logic                         run_permit_pin,
   input  wire dfs_pkg::dfs_config_type      cfg,
   input  wire logic [15:0]                  actual_frequency,
   input  wire logic [15:0]                  actual_current,
   output      logic [15:0]                  frequency_reference_one,
   output      logic                         frequency_reference_one_valid,
   output      logic [15:0]                  reference_two,
   output      logic                         reference_two_valid,
   output      logic [15:0]                  status_word
);

   // ***********************************************
   // State and local signals
   // ***********************************************
   typedef struct packed
   {
      logic [15:0] speed_reference_one;
      logic [15:0] speed_reference_two;
      logic [15:0] output_frequency_actual;
      logic [15:0] output_current_actual;
      logic [15:0] rdata;
      logic        rvalid;
      logic [15:0] ref_one_out;
      logic        ref_one_vld;
      logic [15:0] ref_two_out;
      logic        ref_two_vld;
   } dfs_main_state_type;

   dfs_main_state_type st_r;
   dfs_main_state_type st_nxt;
   logic signed [17:0] corr_one;
   logic signed [17:0] corr_two;
   logic signed [34:0] prod_one;
   logic signed [34:0] prod_two;
   logic               sel_one;
   logic               sel_two;
   logic [15:0]        sw_word;

   // Clamp a wide signed value into a signed 16-bit word
   function automatic logic [15:0] dfs_sat16(input logic signed [34:0] v);
      logic [15:0] r;
      if (v > 35'sh0_0000_7FFF)
         r = 16'h7FFF;
      else if (v < -35'sh0_0000_8000)
         r = 16'h8000;
      else
         r = v[15:0];
      return r;
   endfunction : dfs_sat16

   // ***********************************************
   // Sub-blocks
   // ***********************************************
   dfs_status_word u_status (
      .ref_clk        (ref_clk),
      .nrst           (nrst),
      .flags          (drive_flags),
      .run_permit_pin (run_permit_pin),
      .status_word    (sw_word)
   );

   dfs_ref_correct #(
      .FULL_SCALE (dfs_pkg::DFS_REF_ONE_FULL)
   ) u_corr_one (
      .ref_clk          (ref_clk),
      .nrst             (nrst),
      .fieldbus_ref     (st_r.speed_reference_one),
      .mode             (cfg.ref_one_source),
      .analog_input_one (cfg.analog_input_one),
      .corrected        (corr_one)
   );

   dfs_ref_correct #(
      .FULL_SCALE (dfs_pkg::DFS_REF_TWO_FULL)
   ) u_corr_two (
      .ref_clk          (ref_clk),
      .nrst             (nrst),
      .fieldbus_ref     (st_r.speed_reference_two),
      .mode             (cfg.ref_two_source),
      .analog_input_one (cfg.analog_input_one),
      .corrected        (corr_two)
   );

   // ***********************************************
   // Reference selection and scaling
   // ***********************************************
   // Any of the three fieldbus choices selects the reference
   assign sel_one  = (cfg.ref_one_source != dfs_pkg::DFS_SRC_OTHER)
                     && !drive_flags.location_two_selected;                   // RULE12 RULE16
   assign sel_two  = (cfg.ref_two_source != dfs_pkg::DFS_SRC_OTHER)
                     && drive_flags.location_two_selected;                    // RULE13 RULE16
   // Full-scale products; minimum of reference two plays no part
   assign prod_one = 35'(corr_one) * 35'($signed({1'b0, cfg.max_output_frequency}));  // RULE15
   assign prod_two = 35'(corr_two) * 35'($signed({1'b0, cfg.reference_two_maximum})); // RULE14

   // ***********************************************
   // Next state: register access and outputs
   // ***********************************************
   always_comb
   begin
      st_nxt = st_r;
      // Actual values are sampled every cycle and never written by the bus
      st_nxt.output_frequency_actual = actual_frequency;                      // RULE21 RULE22
      st_nxt.output_current_actual   = actual_current;                        // RULE21 RULE23
      // Writes reach the two reference holding registers only
      if (reg_req.wr)
      begin
         case (reg_req.addr)
            dfs_pkg::DFS_OFS_REF_ONE: st_nxt.speed_reference_one = reg_req.wdata; // RULE10
            dfs_pkg::DFS_OFS_REF_TWO: st_nxt.speed_reference_two = reg_req.wdata; // RULE10
            default: st_nxt.rvalid = st_r.rvalid;
         endcase
      end
      // Reads answer one cycle later; unmapped addresses read zero
      st_nxt.rvalid = reg_req.rd;
      st_nxt.rdata  = dfs_pkg::DFS_WORD_RESET;
      if (reg_req.rd)
      begin
         case (reg_req.addr)
            dfs_pkg::DFS_OFS_REF_ONE: st_nxt.rdata = st_r.speed_reference_one;
            dfs_pkg::DFS_OFS_REF_TWO: st_nxt.rdata = st_r.speed_reference_two;
            dfs_pkg::DFS_OFS_STATUS:  st_nxt.rdata = sw_word;                 // RULE1
            dfs_pkg::DFS_OFS_FREQ:    st_nxt.rdata = st_r.output_frequency_actual; // RULE22
            dfs_pkg::DFS_OFS_CURR:    st_nxt.rdata = st_r.output_current_actual;   // RULE23
            default:                  st_nxt.rdata = dfs_pkg::DFS_WORD_RESET;
         endcase
      end
      // Scaled references; zero while the fieldbus is not the source
      st_nxt.ref_one_vld = sel_one;                                           // RULE12
      st_nxt.ref_one_out = sel_one ?
         dfs_sat16(prod_one / 35'(dfs_pkg::DFS_REF_ONE_FULL)) : dfs_pkg::DFS_WORD_RESET; // RULE15
      st_nxt.ref_two_vld = sel_two;                                           // RULE13
      st_nxt.ref_two_out = sel_two ?
         dfs_sat16(prod_two / 35'(dfs_pkg::DFS_REF_TWO_FULL)) : dfs_pkg::DFS_WORD_RESET; // RULE14
   end

   // State register
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   assign reg_rdata                     = st_r.rdata;
   assign reg_rvalid                    = st_r.rvalid;
   assign frequency_reference_one       = st_r.ref_one_out;
   assign frequency_reference_one_valid = st_r.ref_one_vld;
   assign reference_two                 = st_r.ref_two_out;
   assign reference_two_valid           = st_r.ref_two_vld;
   assign status_word                   = sw_word;

   // ***********************************************
   // Assertions and covers
   // ***********************************************
   default clocking dfs_cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   unused_bits_a : assert property (status_word[15:13] == 3'h0) // RULE9
      else $error("Unused status bits are not zero");

   alarm_bit_a : assert property (##1 status_word[7] == $past(drive_flags.alarm_active)) // RULE3
      else $error("Alarm bit does not follow alarm flag");

   run_permit_a : assert property (##3 status_word[12] == $past(run_permit_pin, 3)) // RULE8
      else $error("Run permit bit not three cycles behind pin");

   status_read_a : assert property ( // RULE1
      reg_req.rd && reg_req.addr == dfs_pkg::DFS_OFS_STATUS
      |=> reg_rvalid && reg_rdata == $past(status_word))
      else $error("Status read returned wrong word");

   ref_write_a : assert property ( // RULE10
      reg_req.wr && reg_req.addr == dfs_pkg::DFS_OFS_REF_ONE
      ##1 !reg_req.wr
      ##1 reg_req.rd && reg_req.addr == dfs_pkg::DFS_OFS_REF_ONE && !reg_req.wr
      |=> reg_rdata == $past(reg_req.wdata, 3))
      else $error("Reference one readback differs from written word");

   freq_read_a : assert property ( // RULE22
      ##2 reg_req.rd && reg_req.addr == dfs_pkg::DFS_OFS_FREQ
      |=> reg_rdata == $past(actual_frequency, 2))
      else $error("Frequency actual value read wrong");

   curr_read_a : assert property ( // RULE23
      ##2 reg_req.rd && reg_req.addr == dfs_pkg::DFS_OFS_CURR
      |=> reg_rdata == $past(actual_current, 2))
      else $error("Current actual value read wrong");

   ro_write_a : assert property ( // RULE21
      reg_req.wr && reg_req.addr == dfs_pkg::DFS_OFS_FREQ
      && reg_req.wdata != actual_frequency
      |=> st_r.output_frequency_actual == $past(actual_frequency))
      else $error("Write reached read-only actual value");

   ref_one_gate_a : assert property ( // RULE12
      frequency_reference_one_valid == $past(sel_one)
      && (!frequency_reference_one_valid -> frequency_reference_one == 16'h0000))
      else $error("Reference one used without fieldbus location one");

   ref_two_gate_a : assert property ( // RULE13
      reference_two_valid |-> $past(drive_flags.location_two_selected)
      && $past(cfg.ref_two_source) != dfs_pkg::DFS_SRC_OTHER)
      else $error("Reference two used without fieldbus location two");

   neutral_a : assert property ( // RULE18
      cfg.analog_input_one == 14'(dfs_pkg::DFS_AI_NEUTRAL)
      |=> corr_one == 18'($signed($past(st_r.speed_reference_one))))
      else $error("Neutral analog input changed reference one");

   ref_two_full_a : assert property ( // RULE14
      sel_two && corr_two == 18'(dfs_pkg::DFS_REF_TWO_FULL)
      && !cfg.reference_two_maximum[15]
      |=> reference_two == $past(cfg.reference_two_maximum))
      else $error("Reference two full scale does not equal maximum");

   reverse_a : assert property ( // RULE11
      sel_one && corr_one < 0 |=> $signed(frequency_reference_one) <= 0)
      else $error("Negative reference one gave forward frequency");

   ref_one_write_c : cover property (
      reg_req.wr && reg_req.addr == dfs_pkg::DFS_OFS_REF_ONE ##2 frequency_reference_one_valid);

   plus_mode_c : cover property (
      sel_one && cfg.ref_one_source == dfs_pkg::DFS_SRC_PLUS ##1 frequency_reference_one_valid);

   times_mode_c : cover property (
      sel_two && cfg.ref_two_source == dfs_pkg::DFS_SRC_TIMES ##1 reference_two_valid);

   status_read_c : cover property (
      reg_req.rd && reg_req.addr == dfs_pkg::DFS_OFS_STATUS ##1 reg_rvalid);

endmodule : dfs_fieldbus_if

// ### dfs_master_model.sv
// Fieldbus master station model issuing holding register reads and writes
`timescale 1ns/100ps
module dfs_master_model (
   input  wire logic                     ref_clk,
   output      dfs_pkg::dfs_reg_req_type reg_req,
   input  wire logic [15:0]              reg_rdata,
   input  wire logic                     reg_rvalid
);
   // ***********************************************
   // Register access tasks
   // ***********************************************
   initial reg_req = '0;

   // One write strobe; the word is a sign bit and 15-bit magnitude
   task automatic put(input logic [15:0] addr, input logic [15:0] data);
      @(posedge ref_clk);
      reg_req.addr  <= addr;
      reg_req.wdata <= data;
      reg_req.wr    <= 1'h1;
      @(posedge ref_clk);
      reg_req.wr    <= 1'h0;
      reg_req.wdata <= ~data; // Old data is not left on the lines
   endtask : put

   // One read strobe, then a bounded wait for the answer
   task automatic get(input logic [15:0] addr, output logic [15:0] data, output bit ok);
      data = 'x;
      ok = 1'h0;
      @(posedge ref_clk);
      reg_req.addr <= addr;
      reg_req.rd   <= 1'h1;
      @(posedge ref_clk);
      reg_req.rd   <= 1'h0;
      // The answer stands for the one cycle after the read edge
      for (int i = 0; i < 4 && !ok; i++)
      begin
         #1;
         ok   = (reg_rvalid === 1'h1);
         data = reg_rdata;
         if (!ok)
            @(posedge ref_clk);
      end
   endtask : get
endmodule : dfs_master_model

// ### drive_fieldbus_status_reference_tb_top.sv
// Self-checking bench of the fieldbus status and reference block
`timescale 1ns/100ps
module drive_fieldbus_status_reference_tb_top;
   logic                         ref_clk = 1'h0;
   logic                         nrst = 1'h0;
   dfs_pkg::dfs_reg_req_type     reg_req;
   logic [15:0]                  reg_rdata;
   logic                         reg_rvalid;
   dfs_pkg::dfs_drive_flags_type drive_flags = '0;
   logic                         run_permit_pin = 1'h0;
   dfs_pkg::dfs_config_type      cfg = '0;
   logic [15:0]                  actual_frequency = '0;
   logic [15:0]                  actual_current = '0;
   logic [15:0]                  fref_one;
   logic                         fref_one_valid;
   logic [15:0]                  ref_two;
   logic                         ref_two_valid;
   logic [15:0]                  status_word;
   int                           fails = 0;
   int                           n_compared = 0;

   // ***********************************************
   // Clock, design and master model
   // ***********************************************
   always #50 ref_clk = ~ref_clk;

   dfs_fieldbus_if u_dut (
      .ref_clk                       (ref_clk),
      .nrst                          (nrst),
      .reg_req                       (reg_req),
      .reg_rdata                     (reg_rdata),
      .reg_rvalid                    (reg_rvalid),
      .drive_flags                   (drive_flags),
      .run_permit_pin                (run_permit_pin),
      .cfg                           (cfg),
      .actual_frequency              (actual_frequency),
      .actual_current                (actual_current),
      .frequency_reference_one       (fref_one),
      .frequency_reference_one_valid (fref_one_valid),
      .reference_two                 (ref_two),
      .reference_two_valid           (ref_two_valid),
      .status_word                   (status_word)
   );

   dfs_master_model u_master (
      .ref_clk    (ref_clk),
      .reg_req    (reg_req),
      .reg_rdata  (reg_rdata),
      .reg_rvalid (reg_rvalid)
   );

   // ***********************************************
   // Compare, expectation and closing tasks
   // ***********************************************
   task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk_word(what, {15'h0, exp}, {15'h0, got});
   endtask : chk_bit

   task automatic tally_and_finish();
      if (fails == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   // Register read with the answer compared; a lost answer ends the run
   task automatic rd_chk(input string what, input logic [15:0] addr, input logic [15:0] exp);
      logic [15:0] rd;
      bit          ok;
      u_master.get(addr, rd, ok);
      if (!ok)
      begin
         fails++;
         tally_and_finish();
      end
      chk_word(what, exp, rd);
   endtask : rd_chk

   // Corrected and scaled reference, 50 percent neutral
   function automatic logic [15:0] exp_ref(input int src, input int ai, input int r, input int mx, input int full);
      int c;
      c = (src == 2) ? r + (ai - dfs_pkg::DFS_AI_NEUTRAL) * full / dfs_pkg::DFS_REF_TWO_FULL
        : (src == 3) ? r * ai / dfs_pkg::DFS_AI_NEUTRAL : r;
      c = c * mx / full;
      return c[15:0];
   endfunction : exp_ref

   // Bound on the whole run
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      tally_and_finish();
   end

   // ***********************************************
   // Main sequence
   // ***********************************************
   initial
   begin
      int                ai_tab [4] = '{32'h0, 32'hBB8, 32'h1388, 32'h2710};
      logic signed [15:0] r_tab [2] = '{16'sh1388, 16'shEC78};
      repeat (20) @(posedge ref_clk);
      nrst <= 1'h1;
      @(posedge ref_clk);
      #1;
      chk_word("status_word", 16'h0000, status_word);
      for (int j = 0; j < 12; j++)
      begin
         @(posedge ref_clk);
         drive_flags <= dfs_pkg::dfs_drive_flags_type'(12'h800 >> j);
         repeat (2) @(posedge ref_clk);
         #1;
         chk_word("status_word", 16'h0001 << j, status_word);
      end
      @(posedge ref_clk);
      drive_flags    <= '1;
      run_permit_pin <= 1'h1;
      repeat (4) @(posedge ref_clk);
      #1;
      chk_word("status_word", 16'h1FFF, status_word);
      rd_chk("status register", dfs_pkg::DFS_OFS_STATUS, 16'h1FFF);
      @(posedge ref_clk);
      actual_frequency <= 16'hEC78;
      actual_current   <= 16'h0064;
      drive_flags      <= '0;
      cfg.max_output_frequency  <= 16'h1388;
      cfg.reference_two_maximum <= 16'h03E8;
      u_master.put(dfs_pkg::DFS_OFS_FREQ, 16'h1234);
      rd_chk("output_frequency_actual", dfs_pkg::DFS_OFS_FREQ, 16'hEC78);
      rd_chk("output_current_actual", dfs_pkg::DFS_OFS_CURR, 16'h0064);
      rd_chk("unmapped register", 16'h9C47, 16'h0000);
      // Every fieldbus source, four analog levels and both directions for reference one
      for (int s = 1; s < 4; s++)
         for (int k = 0; k < 4; k++)
            for (int h = 0; h < 2; h++)
            begin
               @(posedge ref_clk);
               cfg.ref_one_source   <= dfs_pkg::dfs_source_type'(s);
               cfg.analog_input_one <= ai_tab[k][13:0];
               u_master.put(dfs_pkg::DFS_OFS_REF_ONE, r_tab[h]);
               rd_chk("speed_reference_one", dfs_pkg::DFS_OFS_REF_ONE, r_tab[h]);
               repeat (4) @(posedge ref_clk);
               #1;
               chk_word("frequency_reference_one",
                        exp_ref(s, ai_tab[k], int'(r_tab[h]), 32'h1388, dfs_pkg::DFS_REF_ONE_FULL),
                        fref_one);
               chk_bit("frequency_reference_one_valid", 1'h1, fref_one_valid);
            end
      // Location two takes reference two and drops reference one
      @(posedge ref_clk);
      drive_flags.location_two_selected <= 1'h1;
      u_master.put(dfs_pkg::DFS_OFS_REF_TWO, 16'h1388);
      for (int s = 0; s < 4; s++)
      begin
         @(posedge ref_clk);
         cfg.ref_two_source <= dfs_pkg::dfs_source_type'(s);
         repeat (4) @(posedge ref_clk);
         #1;
         chk_word("reference_two", (s == 0) ? 16'h0000
                  : exp_ref(s, ai_tab[3], 32'h1388, 32'h3E8, dfs_pkg::DFS_REF_TWO_FULL), ref_two);
         chk_bit("reference_two_valid", s != 0, ref_two_valid);
         chk_bit("frequency_reference_one_valid", 1'h0, fref_one_valid);
         chk_word("frequency_reference_one", 16'h0000, fref_one);
      end
      tally_and_finish();
   end
endmodule : drive_fieldbus_status_reference_tb_top
